// ==== rtl/ttcr_timer.sv ====
`timescale 1ns/1ps
`include "ttcr_consts.svh"

module ttcr_timer
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        trigger_input,
    input  wire logic        count_pin_in,
    output logic             count_pin_out,
    output logic             count_pin_oe,
    // system
    input  wire logic        t1_overflow,
    output logic             timer_irq,
    output logic             uart_rx_clk,
    output logic             uart_tx_clk
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    ttcr_pkg::ttcr_ctrl_s  ctrl_r;
    ttcr_pkg::ttcr_tmode_s tmode_r;
    ttcr_pkg::ttcr_mode_e  mode;
    logic [15:0]           cnt_r;
    logic [15:0]           cap_r;
    logic [2:0]            mc_r;
    logic                  mc_tick;
    logic                  trg_last_r;
    logic                  trg_pend_r;
    logic                  pin_last_r;
    logic                  pin_fall;
    logic                  trg_act;
    logic                  tick;
    logic                  down;
    logic                  up_roll;
    logic                  dn_match;
    logic                  ovf;
    logic                  wr_en;
    logic [9:0]            widx;
    logic                  cnt_wr;
    logic [31:0]           rd_val;
    logic                  rd_hit;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;
    logic                  irq_r;
    logic                  rxc_r;
    logic                  txc_r;
    logic                  pin_out_r;
    logic                  pin_oe_r;

    // ----------------------------------------
    // mode selection
    // ----------------------------------------
    always_comb
    begin
        if (!ctrl_r.run_control)
            mode = ttcr_pkg::mode_off;
        else if (ctrl_r.uart_rx_clock_select || ctrl_r.uart_tx_clock_select)
            mode = ttcr_pkg::mode_baud;
        else if (tmode_r.clock_out_enable)
            mode = ttcr_pkg::mode_clkout;
        else if (ctrl_r.capture_reload_select)
            mode = ttcr_pkg::mode_capture;
        else
            mode = ttcr_pkg::mode_reload;
    end

    // ----------------------------------------
    // machine cycle and input sampling
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mc_r <= `TTCR_MC_ZERO;
        else if (mc_r == `TTCR_MC_LAST)
            mc_r <= `TTCR_MC_ZERO;
        else
            mc_r <= mc_r + `TTCR_MC_STEP;
    end

    assign mc_tick = (mc_r == `TTCR_MC_LAST);

    // pins are sampled once a machine cycle, so pulses shorter than one can be missed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trg_last_r <= 1'b0;
            trg_pend_r <= 1'b0;
            pin_last_r <= 1'b0;
        end
        else if (mc_tick)
        begin
            trg_last_r <= trigger_input;
            trg_pend_r <= trg_last_r && !trigger_input;
            pin_last_r <= count_pin_in;
        end
    end

    // edge acts at the third sample, ignored when triggering is off
    assign trg_act  = mc_tick && trg_pend_r && ctrl_r.external_trigger_enable;
    assign pin_fall = mc_tick && pin_last_r && !count_pin_in;

    // ----------------------------------------
    // count source and events
    // ----------------------------------------
    always_comb
    begin
        if (mode == ttcr_pkg::mode_off)
            tick = 1'b0;
        else if (ctrl_r.counter_select)
            tick = pin_fall;
        else if (mode == ttcr_pkg::mode_baud || mode == ttcr_pkg::mode_clkout)
            tick = 1'b1;
        else
            tick = mc_tick;
    end

    // direction from the trigger pin only in plain reload mode
    assign down = (mode == ttcr_pkg::mode_reload) && tmode_r.down_count_enable
                  && !trigger_input;
    assign up_roll  = tick && !down && (cnt_r == `TTCR_ALL_ONES);
    assign dn_match = tick && down && (cnt_r == cap_r);
    assign ovf      = up_roll || dn_match;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign wr_en  = psel && penable && pwrite && pready_r;
    assign widx   = paddr[11:2];
    assign cnt_wr = wr_en && (widx == `TTCR_IDX_CNTL || widx == `TTCR_IDX_CNTH);

    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (widx)
            `TTCR_IDX_CTRL: rd_val[7:0] = ctrl_r;
            `TTCR_IDX_MODE: rd_val[1:0] = tmode_r;
            `TTCR_IDX_CAPL: rd_val[7:0] = cap_r[7:0];
            `TTCR_IDX_CAPH: rd_val[7:0] = cap_r[15:8];
            `TTCR_IDX_CNTL: rd_val[7:0] = cnt_r[7:0];
            `TTCR_IDX_CNTH: rd_val[7:0] = cnt_r[15:8];
            default:        rd_hit = 1'b0;
        endcase
    end

    // one wait-free access: answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= psel && !penable;
            prdata_r  <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
            pslverr_r <= psel && !penable && !rd_hit;
        end
    end

    // ----------------------------------------
    // control and mode registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= `TTCR_CTRL_RST;
        else
        begin
            if (wr_en && widx == `TTCR_IDX_CTRL)
                ctrl_r <= pwdata[7:0];
            // hardware sets win over a software clear in the same cycle
            if (ovf && (mode == ttcr_pkg::mode_reload ||
                        mode == ttcr_pkg::mode_capture))
                ctrl_r.overflow_flag <= 1'b1;
            if (mode == ttcr_pkg::mode_reload && tmode_r.down_count_enable)
            begin
                if (ovf)
                    ctrl_r.external_edge_flag <= !ctrl_r.external_edge_flag;
            end
            else if (trg_act && mode != ttcr_pkg::mode_off &&
                     mode != ttcr_pkg::mode_clkout)
                ctrl_r.external_edge_flag <= 1'b1;
        end
    end

    // reserved bits are not stored and read back as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tmode_r <= `TTCR_MODE_RST;
        else if (wr_en && widx == `TTCR_IDX_MODE)
            tmode_r <= pwdata[1:0];
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= `TTCR_CNT_RST;
        else if (cnt_wr)
        begin
            if (widx == `TTCR_IDX_CNTL)
                cnt_r[7:0] <= pwdata[7:0];
            else
                cnt_r[15:8] <= pwdata[7:0];
        end
        else if (mode == ttcr_pkg::mode_capture)
        begin
            if (tick)
                cnt_r <= cnt_r + `TTCR_CNT_STEP;
        end
        else if (dn_match)
            cnt_r <= `TTCR_ALL_ONES;
        else if (up_roll)
            cnt_r <= cap_r;
        else if (trg_act && mode == ttcr_pkg::mode_reload && !tmode_r.down_count_enable)
            cnt_r <= cap_r;
        else if (tick)
            cnt_r <= down ? cnt_r - `TTCR_CNT_STEP : cnt_r + `TTCR_CNT_STEP;
    end

    // capture registers are unprotected: a later edge overwrites them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_r <= `TTCR_CNT_RST;
        else if (trg_act && mode == ttcr_pkg::mode_capture)
            cap_r <= cnt_r;
        else if (wr_en && widx == `TTCR_IDX_CAPL)
            cap_r[7:0] <= pwdata[7:0];
        else if (wr_en && widx == `TTCR_IDX_CAPH)
            cap_r[15:8] <= pwdata[7:0];
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_r <= 1'b0;
            rxc_r <= 1'b0;
            txc_r <= 1'b0;
        end
        else
        begin
            irq_r <= ctrl_r.overflow_flag || ctrl_r.external_edge_flag;
            rxc_r <= ctrl_r.uart_rx_clock_select ? ovf : t1_overflow;
            txc_r <= ctrl_r.uart_tx_clock_select ? ovf : t1_overflow;
        end
    end

    // count pin becomes an output toggled per roll-over in clock-out mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
        end
        else
        begin
            pin_oe_r <= (mode == ttcr_pkg::mode_clkout);
            if (mode == ttcr_pkg::mode_clkout && ovf)
                pin_out_r <= !pin_out_r;
        end
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign timer_irq     = irq_r;
    assign uart_rx_clk   = rxc_r;
    assign uart_tx_clk   = txc_r;
    assign count_pin_out = pin_out_r;
    assign count_pin_oe  = pin_oe_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    mode_sel_uart_a: assert property (
        ctrl_r.run_control && (ctrl_r.uart_rx_clock_select || ctrl_r.uart_tx_clock_select)
        |-> mode == ttcr_pkg::mode_baud)
        else $error("uart select did not give baud mode");
    tf_blocked_a: assert property (
        $rose(ctrl_r.overflow_flag) && !$past(wr_en) |->
        $past(mode) == ttcr_pkg::mode_reload || $past(mode) == ttcr_pkg::mode_capture)
        else $error("overflow flag set in wrong mode");
    exf_set_a: assert property (
        trg_act && mode == ttcr_pkg::mode_capture |=> ctrl_r.external_edge_flag)
        else $error("trigger edge lost");
    stop_hold_a: assert property (
        !ctrl_r.run_control && !cnt_wr |=> cnt_r == $past(cnt_r))
        else $error("counter moved while stopped");
    tick_rate_a: assert property (
        tick && !ctrl_r.counter_select && mode == ttcr_pkg::mode_capture |-> mc_r == `TTCR_MC_LAST)
        else $error("internal tick not once per machine cycle");
    cap_copy_a: assert property (
        trg_act && mode == ttcr_pkg::mode_capture |=> cap_r == $past(cnt_r))
        else $error("capture value wrong");
    cap_count_a: assert property (
        tick && mode == ttcr_pkg::mode_capture && !cnt_wr |=>
        cnt_r == $past(cnt_r) + `TTCR_CNT_STEP)
        else $error("capture mode count disturbed");
    up_reload_a: assert property (
        up_roll && mode == ttcr_pkg::mode_reload && !cnt_wr |=> cnt_r == $past(cap_r))
        else $error("reload value wrong");
    down_reload_a: assert property (
        dn_match && !cnt_wr |=> cnt_r == `TTCR_ALL_ONES)
        else $error("down match did not load all ones");
    irq_join_a: assert property (
        (ctrl_r.overflow_flag || ctrl_r.external_edge_flag) |=> timer_irq)
        else $error("interrupt not raised");
    uart_tx_a: assert property (
        ctrl_r.uart_tx_clock_select && ovf ##1 ctrl_r.uart_tx_clock_select |-> uart_tx_clk)
        else $error("transmit clock pulse missing");
endmodule

// ==== include/ttcr_consts.svh ====
`ifndef TTCR_CONSTS_SVH
`define TTCR_CONSTS_SVH
// register indices; byte address is four times the index
`define TTCR_IDX_CTRL 10'h0c8
`define TTCR_IDX_MODE 10'h0c9
`define TTCR_IDX_CAPL 10'h0ca
`define TTCR_IDX_CAPH 10'h0cb
`define TTCR_IDX_CNTL 10'h0cc
`define TTCR_IDX_CNTH 10'h0cd
// reset values
`define TTCR_CTRL_RST 8'h00
`define TTCR_MODE_RST 2'h0
`define TTCR_CNT_RST  16'h0000
// one machine cycle is six oscillator clocks
`define TTCR_MC_LAST  3'h5
`define TTCR_MC_ZERO  3'h0
`define TTCR_MC_STEP  3'h1
`define TTCR_ALL_ONES 16'hffff
`define TTCR_CNT_STEP 16'h0001
`endif

// ==== include/ttcr_pkg.sv ====
package ttcr_pkg;

    typedef struct packed
    {
        logic overflow_flag;
        logic external_edge_flag;
        logic uart_rx_clock_select;
        logic uart_tx_clock_select;
        logic external_trigger_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } ttcr_ctrl_s;

    typedef struct packed
    {
        logic clock_out_enable;
        logic down_count_enable;
    } ttcr_tmode_s;

    typedef enum logic [2:0]
    {
        mode_off     = 3'b000,
        mode_reload  = 3'b001,
        mode_capture = 3'b010,
        mode_clkout  = 3'b011,
        mode_baud    = 3'b100
    } ttcr_mode_e;

endpackage

// ==== tb/ttcr_pin_model.sv ====
`timescale 1ns/1ps

module ttcr_pin_model
(
    // clock
    input  wire logic pclk,
    // design side of the count pin
    input  wire logic count_pin_out,
    input  wire logic count_pin_oe,
    // pin levels seen by the design
    output logic      trigger_input,
    output logic      count_pin_in
);
    logic drv;

    initial
    begin
        trigger_input = 1'b1;
        drv = 1'b1;
    end

    // the design owns the pin while it drives the clock-out level
    assign count_pin_in = count_pin_oe ? count_pin_out : drv;

    // levels outlast two machine cycles so a sample always lands on them
    task trig_set(input logic v, input int hold);
        @(posedge pclk);
        trigger_input <= v;
        repeat (hold) @(posedge pclk);
    endtask

    task trig_fall();
        trig_set(1'b1, 12);
        trig_set(1'b0, 18);
        trig_set(1'b1, 12);
    endtask

    // a 15 clock period keeps below the external rate ceiling
    task pulses(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            drv <= 1'b0;
            repeat (7) @(posedge pclk);
            drv <= 1'b1;
            repeat (7) @(posedge pclk);
        end
    endtask
endmodule

// ==== tb/test_ttcr_timer.sv ====
`timescale 1ns/1ps
`include "ttcr_consts.svh"

module test_ttcr_timer;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] v;
    logic        trig, cin, cout, coe, t1_ovf, irq, rxc, txc, last_out;
    int          err_total, comparisons, cyc, rx_n, tx_n, tog_n;

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    ttcr_timer dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_input(trig),
        .count_pin_in(cin), .count_pin_out(cout), .count_pin_oe(coe),
        .t1_overflow(t1_ovf), .timer_irq(irq), .uart_rx_clk(rxc), .uart_tx_clk(txc)
    );

    ttcr_pin_model m
    (
        .pclk(pclk), .count_pin_out(cout), .count_pin_oe(coe),
        .trigger_input(trig), .count_pin_in(cin)
    );

    // ----------------------------------------
    // bookkeeping and hang guard
    // ----------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (rxc === 1'b1) rx_n++;
        if (txc === 1'b1) tx_n++;
        if (cout !== last_out) tog_n++;
        last_out = cout;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task in_range(input int x, input int lo, input int hi);
        check({31'h0, x >= lo && x <= hi}, 32'h1);
    endtask

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task rdc(input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check(q, {24'h000000, e});
    endtask

    task set16(input logic [9:0] idx, input logic [15:0] d);
        wr(idx, d[7:0]);
        wr(idx + 10'h001, d[15:8]);
    endtask

    task rd16(input logic [9:0] idx);
        apb(1'b0, idx, 8'h00);
        v[7:0] = q[7:0];
        apb(1'b0, idx + 10'h001, 8'h00);
        v[15:8] = q[7:0];
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs();
        rdc(`TTCR_IDX_CTRL, 8'h00);
        rdc(`TTCR_IDX_MODE, 8'h00);
        rdc(`TTCR_IDX_CNTL, 8'h00);
        apb(1'b0, 10'h0ff, 8'h00);
        check({31'h0, serr}, 32'h1);
        set16(`TTCR_IDX_CAPL, 16'h5aa5);
        rd16(`TTCR_IDX_CAPL);
        check({16'h0, v}, 32'h5aa5);
        $display("registers done");
    endtask

    task t_rate();
        set16(`TTCR_IDX_CNTL, 16'h0000);
        wr(`TTCR_IDX_CTRL, 8'h05);
        repeat (600) @(posedge pclk);
        wr(`TTCR_IDX_CTRL, 8'h01);
        rd16(`TTCR_IDX_CNTL);
        in_range(v, 99, 101);
        repeat (30) @(posedge pclk);
        rd16(`TTCR_IDX_CNTL);
        in_range(v, 99, 101);
        $display("rate done");
    endtask

    task t_ovf();
        set16(`TTCR_IDX_CAPL, 16'h1234);
        set16(`TTCR_IDX_CNTL, 16'hfffe);
        wr(`TTCR_IDX_CTRL, 8'h05);
        repeat (30) @(posedge pclk);
        rdc(`TTCR_IDX_CTRL, 8'h85);
        check({31'h0, irq}, 32'h1);
        wr(`TTCR_IDX_CTRL, 8'h01);
        rdc(`TTCR_IDX_CNTH, 8'h00);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        $display("overflow done");
    endtask

    task t_cap();
        set16(`TTCR_IDX_CNTL, 16'habcd);
        wr(`TTCR_IDX_CTRL, 8'h0f);
        m.trig_fall();
        rdc(`TTCR_IDX_CTRL, 8'h4f);
        rd16(`TTCR_IDX_CAPL);
        check({16'h0, v}, 32'habcd);
        m.pulses(3);
        rd16(`TTCR_IDX_CNTL);
        check({16'h0, v}, 32'habd0);
        wr(`TTCR_IDX_CTRL, 8'h07);
        m.trig_fall();
        rdc(`TTCR_IDX_CTRL, 8'h07);
        rd16(`TTCR_IDX_CAPL);
        check({16'h0, v}, 32'habcd);
        $display("capture done");
    endtask

    task t_reload();
        set16(`TTCR_IDX_CAPL, 16'h1200);
        set16(`TTCR_IDX_CNTL, 16'hffff);
        wr(`TTCR_IDX_CTRL, 8'h06);
        m.pulses(1);
        rd16(`TTCR_IDX_CNTL);
        check({16'h0, v}, 32'h1200);
        rdc(`TTCR_IDX_CTRL, 8'h86);
        wr(`TTCR_IDX_CTRL, 8'h0e);
        set16(`TTCR_IDX_CNTL, 16'h0005);
        m.trig_fall();
        rd16(`TTCR_IDX_CNTL);
        check({16'h0, v}, 32'h1200);
        rdc(`TTCR_IDX_CTRL, 8'h4e);
        // down counting: reload all ones on reaching the capture value
        wr(`TTCR_IDX_MODE, 8'h01);
        m.trig_set(1'b0, 12);
        wr(`TTCR_IDX_CTRL, 8'h06);
        set16(`TTCR_IDX_CAPL, 16'h0010);
        set16(`TTCR_IDX_CNTL, 16'h0011);
        m.pulses(2);
        rd16(`TTCR_IDX_CNTL);
        check({16'h0, v}, 32'hffff);
        rdc(`TTCR_IDX_CTRL, 8'hc6);
        m.trig_set(1'b1, 12);
        $display("reload done");
    endtask

    task t_baud();
        wr(`TTCR_IDX_MODE, 8'h00);
        wr(`TTCR_IDX_CTRL, 8'h00);
        set16(`TTCR_IDX_CAPL, 16'hfff0);
        set16(`TTCR_IDX_CNTL, 16'hfff0);
        rx_n = 0;
        tx_n = 0;
        wr(`TTCR_IDX_CTRL, 8'h24);
        repeat (160) @(posedge pclk);
        in_range(rx_n, 9, 11);
        check(tx_n, 0);
        rdc(`TTCR_IDX_CTRL, 8'h24);
        @(posedge pclk);
        t1_ovf <= 1'b1;
        @(posedge pclk);
        t1_ovf <= 1'b0;
        repeat (3) @(posedge pclk);
        check(tx_n, 1);
        // transmit side from this timer, receive side back on timer one
        wr(`TTCR_IDX_CTRL, 8'h14);
        repeat (2) @(posedge pclk);
        rx_n = 0;
        tx_n = 0;
        repeat (160) @(posedge pclk);
        in_range(tx_n, 9, 11);
        check(rx_n, 0);
        $display("baud done");
    endtask

    task t_clkout();
        wr(`TTCR_IDX_CTRL, 8'h00);
        wr(`TTCR_IDX_MODE, 8'h02);
        set16(`TTCR_IDX_CAPL, 16'hfff8);
        set16(`TTCR_IDX_CNTL, 16'hfff8);
        wr(`TTCR_IDX_CTRL, 8'h04);
        repeat (4) @(posedge pclk);
        check({31'h0, coe}, 32'h1);
        tog_n = 0;
        repeat (80) @(posedge pclk);
        in_range(tog_n, 9, 11);
        rdc(`TTCR_IDX_CTRL, 8'h04);
        wr(`TTCR_IDX_CTRL, 8'h00);
        repeat (3) @(posedge pclk);
        check({31'h0, coe}, 32'h0);
        $display("clock-out done");
    endtask

    task wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        t1_ovf = 1'b0;
        last_out = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_rate();
        t_ovf();
        t_cap();
        t_reload();
        t_baud();
        t_clkout();
        wrap_up();
    end
endmodule
